// File: adc_out_pkg.sv
// Constants and types for the converter output stage.
// Assumes an 9-bit register address space decoded upstream by the control port.
package adc_out_pkg;

    // Register offsets
    localparam logic [8:0] OUT_MODE_ADDR = 9'h014;
    localparam logic [8:0] OUT_CLK_ADDR  = 9'h016;
    localparam logic [8:0] OVR_ADDR      = 9'h111;

    // Field positions
    localparam int FMT_LSB     = 0;
    localparam int SWING_BIT   = 7;
    localparam int DCO_INV_BIT = 7;
    localparam int THR_SHIFT   = 9;

    // Reset values
    localparam logic [7:0] OUT_MODE_RST = 8'h00;
    localparam logic [7:0] OUT_CLK_RST  = 8'h00;
    localparam logic [7:0] OVR_RST      = 8'h00;

    // Codes and counts
    localparam logic [16:0] CLIP_CODE       = 17'h07FFF;
    localparam int          MOD_TRIP_CYCLES = 16;
    localparam int          AUTO_RST_CYCLES = 32;

    typedef enum logic [1:0] {
        FMT_OFFSET = 2'b00,
        FMT_TWOS   = 2'b01,
        FMT_GRAY   = 2'b10,
        FMT_RSVD   = 2'b11
    } out_format_t;

    typedef enum logic {
        AR_IDLE = 1'b0,
        AR_BUSY = 1'b1
    } ar_state_t;

    typedef struct packed {
        logic       auto_reset_on_overrange;
        logic       overrange_indicate_mode;
        logic [5:0] overrange_threshold_code;
    } ovr_ctrl_t;

endpackage : adc_out_pkg

// File: adc_output_format_overrange.sv
// Output stage: coded sample word, data clock and overrange flag with auto reset.
// Assumes sample_strobe is a one-cycle pulse per output sample, at least two cycles apart,
// from logic on sys_clk; analog_trip comes from the modulator's clock domain.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RQ1: Encode offset binary, twos complement or Gray
// RQ2: Sixteen data bits plus a data clock
// RQ3: One bit selects full or reduced swing
// RQ4: Flag registered, updated once per sample
// RQ5: Analog and digital trip are separate sources
// RQ6: Code zero trips only on clipped output
// RQ7: Nonzero code sets digital trip level
// RQ8: Indicate mode: flag is analog or digital
// RQ9: Indicate with bit five: inverted data valid
// RQ10: Auto reset restarts converter on overrange
// RQ11: Flag held high during auto reset
// RQ12: Modulator resets after sixteen trip cycles
// RQ13: Data valid on rising edge, invertible
// RQ14: Analog trip shows as pulse-width flag
// RQ15: Receiver best captures flag on falling edge; capture_model takes it with the word on the valid edge
// RQ16: Compare magnitude against code times 512
module adc_output_format_overrange
    import adc_out_pkg::*;
#(
    parameter int WIDTH       = 16,
    parameter int RESET_LEN   = AUTO_RST_CYCLES,
    parameter int TRIP_PERIOD = MOD_TRIP_CYCLES
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // Register port
    input  wire logic [8:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic [7:0]       reg_wdata,
    output var  logic [7:0]       reg_rdata,
    // Sample stream from the digital engine
    input  wire logic             sample_strobe,
    input  wire logic [WIDTH-1:0] sample_in,
    input  wire logic             calibrating,
    // Modulator
    input  wire logic             analog_trip,
    output var  logic             modulator_reset,
    // Output pins
    output var  logic [WIDTH-1:0] data_out,
    output var  logic             data_clock_out,
    output var  logic             overrange_flag,
    output logic                  drive_full_swing,
    output logic                  converter_reset
);
    logic [7:0]       out_mode_q;
    logic [7:0]       out_clk_q;
    ovr_ctrl_t        ovr_q;
    logic             trip_s;
    logic [WIDTH-1:0] coded;
    logic [WIDTH:0]   mag;
    logic [WIDTH:0]   thr_level;
    logic             dig_trip;
    logic             any_trip;
    logic             flag_d;
    ar_state_t        ar_state_q;
    logic [$clog2(RESET_LEN+1)-1:0]   ar_cnt_q;
    logic [$clog2(TRIP_PERIOD+1)-1:0] trip_run_q;

    // Register writes
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            out_mode_q <= OUT_MODE_RST;
            out_clk_q  <= OUT_CLK_RST;
            ovr_q      <= ovr_ctrl_t'(OVR_RST);
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                OUT_MODE_ADDR: out_mode_q <= reg_wdata;
                OUT_CLK_ADDR:  out_clk_q  <= reg_wdata;
                OVR_ADDR:      ovr_q      <= ovr_ctrl_t'(reg_wdata);
                default:       ;
            endcase
        end
    end

    // Register reads; unmapped addresses read zero
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            case (reg_addr)
                OUT_MODE_ADDR: reg_rdata <= out_mode_q;
                OUT_CLK_ADDR:  reg_rdata <= out_clk_q;
                OVR_ADDR:      reg_rdata <= ovr_q;
                default:       reg_rdata <= 8'h00;
            endcase
        end
    end

    assign drive_full_swing = out_mode_q[SWING_BIT]; // RQ3

    // The trip comes from the modulator clock, so it is synchronised first
    sync2 u_trip_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (analog_trip),
        .dout    (trip_s)
    );

    output_coder #(
        .WIDTH (WIDTH)
    ) u_coder (
        .fmt    (out_format_t'(out_mode_q[FMT_LSB +: 2])),
        .sample (sample_in),
        .coded  (coded)
    ); // RQ1

    // Sample word and data clock
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            data_out <= '0;
        end
        else if (sample_strobe)
        begin
            data_out <= coded; // RQ2
        end
    end

    // With the clock not inverted it is low in the cycle the word changes and rises one cycle later,
    // so the word has a full cycle of setup before the valid edge
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            data_clock_out <= 1'b0;
        end
        else
        begin
            data_clock_out <= (~sample_strobe) ^ out_clk_q[DCO_INV_BIT]; // RQ13
        end
    end

    // Magnitude is one bit wider so the most negative code does not wrap
    assign mag = sample_in[WIDTH-1] ? ((WIDTH+1)'(1) << WIDTH) - {1'b0, sample_in}
                                    : {1'b0, sample_in};
    assign thr_level = (WIDTH+1)'(ovr_q.overrange_threshold_code) << THR_SHIFT; // RQ16

    always_comb
    begin
        if (ovr_q.overrange_threshold_code == 6'h00)
        begin
            dig_trip = (mag >= CLIP_CODE); // RQ6
        end
        else
        begin
            dig_trip = (mag > thr_level); // RQ7
        end
    end

    assign any_trip = dig_trip | trip_s; // RQ5

    // Flag decision; auto reset does not change it
    always_comb
    begin
        case ({ovr_q.overrange_indicate_mode, ovr_q.overrange_threshold_code[5]})
            2'b10:   flag_d = any_trip; // RQ8
            2'b11:   flag_d = ~(any_trip | calibrating); // RQ9
            default: flag_d = dig_trip;
        endcase
    end

    // Sampling the raw trip once per sample gives the pulse-width look
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            overrange_flag <= 1'b0;
        end
        else if (ar_state_q == AR_BUSY)
        begin
            overrange_flag <= 1'b1; // RQ11
        end
        else if (sample_strobe)
        begin
            overrange_flag <= flag_d; // RQ4 RQ14
        end
    end

    // Auto reset sequencer
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ar_state_q <= AR_IDLE;
            ar_cnt_q   <= '0;
        end
        else
        begin
            case (ar_state_q)
                AR_IDLE:
                begin
                    if (sample_strobe && ovr_q.auto_reset_on_overrange && any_trip)
                    begin
                        ar_state_q <= AR_BUSY; // RQ10
                        ar_cnt_q   <= ($clog2(RESET_LEN+1))'(RESET_LEN - 1);
                    end
                end
                AR_BUSY:
                begin
                    if (ar_cnt_q == '0)
                    begin
                        ar_state_q <= AR_IDLE;
                    end
                    else
                    begin
                        ar_cnt_q <= ar_cnt_q - 1'b1;
                    end
                end
                default: ar_state_q <= AR_IDLE;
            endcase
        end
    end

    assign converter_reset = (ar_state_q == AR_BUSY);

    // Run length of the analog trip; a one-cycle pulse after a full run
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            trip_run_q      <= '0;
            modulator_reset <= 1'b0;
        end
        else if (!trip_s)
        begin
            trip_run_q      <= '0;
            modulator_reset <= 1'b0;
        end
        else if (trip_run_q == ($clog2(TRIP_PERIOD+1))'(TRIP_PERIOD - 1))
        begin
            trip_run_q      <= '0;
            modulator_reset <= 1'b1; // RQ12
        end
        else
        begin
            trip_run_q      <= trip_run_q + 1'b1;
            modulator_reset <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_flag_holds: assert property (
        !sample_strobe && ar_state_q == AR_IDLE && $past(ar_state_q) == AR_IDLE
        |=> $stable(overrange_flag)) // RQ4
        else $error("Flag changed between samples");

    a_clip_trip: assert property (
        sample_strobe && ar_state_q == AR_IDLE && !ovr_q.overrange_indicate_mode
        && ovr_q.overrange_threshold_code == 6'h00 && sample_in == 16'h7FFF
        |=> overrange_flag) // RQ6
        else $error("Clipped sample did not raise flag");

    a_clip_quiet: assert property (
        sample_strobe && ar_state_q == AR_IDLE && !ovr_q.overrange_indicate_mode
        && ovr_q.overrange_threshold_code == 6'h00 && sample_in == 16'h7FFE
        |=> !overrange_flag) // RQ6
        else $error("Flag raised below clip");

    a_thresh_trip: assert property (
        sample_strobe && ar_state_q == AR_IDLE && !ovr_q.overrange_indicate_mode
        && ovr_q.overrange_threshold_code != 6'h00
        && (sample_in[15] ? 17'h10000 - {1'b0, sample_in} : {1'b0, sample_in})
           > 17'(ovr_q.overrange_threshold_code) * 17'd512
        |=> overrange_flag) // RQ7
        else $error("Threshold crossing missed");

    a_full_ovr: assert property (
        sample_strobe && ar_state_q == AR_IDLE && ovr_q.overrange_indicate_mode
        && !ovr_q.overrange_threshold_code[5] && trip_s
        |=> overrange_flag) // RQ8
        else $error("Analog trip not reported");

    a_valid_low: assert property (
        sample_strobe && ar_state_q == AR_IDLE && ovr_q.overrange_indicate_mode
        && ovr_q.overrange_threshold_code[5] && calibrating
        |=> !overrange_flag) // RQ9
        else $error("Data valid not low in calibration");

    a_auto_start: assert property (
        sample_strobe && ar_state_q == AR_IDLE && ovr_q.auto_reset_on_overrange && any_trip
        |=> converter_reset [*2]) // RQ10
        else $error("Auto reset did not start");

    a_reset_flag: assert property (
        converter_reset |=> overrange_flag) // RQ11
        else $error("Flag low during auto reset");

    a_mod_reset: assert property (
        $rose(modulator_reset) |-> $past(trip_s, 1) && $past(trip_s, 16)) // RQ12
        else $error("Modulator reset without full trip run");

    a_twos_word: assert property (
        sample_strobe && out_mode_q[1:0] == 2'b01 |=> data_out == $past(sample_in)) // RQ1
        else $error("Twos complement word wrong");

    a_dco_phase: assert property (
        sample_strobe && $stable(out_clk_q) |=> data_clock_out == out_clk_q[DCO_INV_BIT]
        ##1 data_clock_out != out_clk_q[DCO_INV_BIT] || $past(sample_strobe)) // RQ13
        else $error("Data clock phase wrong");

    c_auto_reset: cover property (sample_strobe && any_trip ##1 converter_reset);
    c_mod_reset:  cover property (modulator_reset);
    c_valid_mode: cover property (ovr_q.overrange_indicate_mode && ovr_q.overrange_threshold_code[5]
                                  && overrange_flag);

endmodule : adc_output_format_overrange
`default_nettype wire

// File: adc_output_format_overrange_bench.sv
// Self-checking bench for the converter output stage.
// Assumes the package, design and capture_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module adc_output_format_overrange_bench;
    import adc_out_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        reg_wr = 1'b0;
    logic        sample_strobe = 1'b0;
    logic        calibrating = 1'b0;
    logic        analog_trip = 1'b0;
    logic        dco_inv = 1'b0;
    logic [1:0]  fmt = 2'h0;
    logic [8:0]  reg_addr = 9'h000;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic [15:0] sample_in = 16'h0000;
    logic [15:0] data_out;
    logic [15:0] cap_data;
    logic        modulator_reset;
    logic        data_clock_out;
    logic        overrange_flag;
    logic        drive_full_swing;
    logic        converter_reset;
    logic        cap_flag;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          mr_count = 0;

    // Short auto reset keeps the run brief
    adc_output_format_overrange #(.RESET_LEN(4)) DUT (.sys_clk, .rst, .reg_addr, .reg_wr,
        .reg_wdata, .reg_rdata, .sample_strobe, .sample_in, .calibrating, .analog_trip,
        .modulator_reset, .data_out, .data_clock_out, .overrange_flag, .drive_full_swing,
        .converter_reset);

    capture_model partner (.data_out, .data_clock_out, .overrange_flag, .dco_inv,
        .cap_data, .cap_flag);

    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (modulator_reset === 1'b1)
            mr_count++;
        if (cycles == 3000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [15:0] coded(input logic [15:0] s);
        logic [15:0] o;
        o = s ^ 16'h8000;
        if (fmt == 2'h1)
            return s;
        if (fmt == 2'h2)
            return o ^ (o >> 1);
        return o;
    endfunction : coded

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        reg_addr = a;
        @(negedge sys_clk);
        check("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd

    // One sample every 200 ns, judged at the pin and at the capture register
    task automatic send(input logic [15:0] s, input logic exp_f);
        @(negedge sys_clk);
        sample_in = s;
        sample_strobe = 1'b1;
        @(negedge sys_clk);
        sample_strobe = 1'b0;
        check("dco_first_cycle", data_clock_out, dco_inv);
        check("flag_pin", overrange_flag, exp_f);
        repeat (6) @(negedge sys_clk);
        check("captured_word", cap_data, coded(s));
        check("captured_flag", cap_flag, exp_f);
    endtask : send

    task automatic t_regs;
        rd(OUT_MODE_ADDR, OUT_MODE_RST);
        rd(OUT_CLK_ADDR, OUT_CLK_RST);
        rd(OVR_ADDR, OVR_RST);
        wr(9'h015, 8'hFF);
        rd(9'h015, 8'h00);
        wr(OUT_MODE_ADDR, 8'h80);
        rd(OUT_MODE_ADDR, 8'h80);
        check("full_swing", drive_full_swing, 1'b1);
        wr(OUT_MODE_ADDR, 8'h00);
        check("full_swing", drive_full_swing, 1'b0);
    endtask : t_regs

    task automatic t_formats;
        for (int f = 0; f < 4; f++)
        begin
            fmt = f[1:0];
            wr(OUT_MODE_ADDR, {6'h00, fmt});
            send(16'h1234, 1'b0);
            send(16'hFFFE, 1'b0);
        end
        fmt = 2'h0;
        wr(OUT_MODE_ADDR, 8'h00);
    endtask : t_formats

    task automatic t_dco_inv;
        wr(OUT_CLK_ADDR, 8'h80);
        dco_inv = 1'b1;
        @(negedge sys_clk);
        check("dco_idle", data_clock_out, 1'b0);
        send(16'h0100, 1'b0);
        wr(OUT_CLK_ADDR, 8'h00);
        dco_inv = 1'b0;
    endtask : t_dco_inv

    task automatic t_thresh;
        logic [7:0]  thr[8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h3F, 8'h3F};
        logic [15:0] smp[8] = '{16'h7FFF, 16'h7FFE, 16'h8000, 16'h0201, 16'h0200,
                                16'hFDFF, 16'h7E01, 16'h7E00};
        logic [0:7]  flg = 8'b10110110;
        for (int i = 0; i < 8; i++)
        begin
            wr(OVR_ADDR, thr[i]);
            send(smp[i], flg[i]);
        end
    endtask : t_thresh

    task automatic t_indicate;
        wr(OVR_ADDR, 8'h40);
        send(16'h7FFF, 1'b1);
        analog_trip = 1'b1;
        repeat (3) @(negedge sys_clk);
        send(16'h0000, 1'b1);
        analog_trip = 1'b0;
        repeat (3) @(negedge sys_clk);
        send(16'h0000, 1'b0);
        wr(OVR_ADDR, 8'h60);
        send(16'h0000, 1'b1);
        calibrating = 1'b1;
        send(16'h0000, 1'b0);
        calibrating = 1'b0;
        analog_trip = 1'b1;
        repeat (3) @(negedge sys_clk);
        send(16'h0000, 1'b0);
        analog_trip = 1'b0;
        wr(OVR_ADDR, 8'h00);
    endtask : t_indicate

    task automatic t_auto;
        wr(OVR_ADDR, 8'h80);
        @(negedge sys_clk);
        sample_in = 16'h7FFF;
        sample_strobe = 1'b1;
        @(negedge sys_clk);
        sample_strobe = 1'b0;
        check("conv_reset", converter_reset, 1'b1);
        repeat (2) @(negedge sys_clk);
        check("conv_reset", converter_reset, 1'b1);
        check("flag_forced", overrange_flag, 1'b1);
        @(negedge sys_clk);
        check("flag_forced", overrange_flag, 1'b1);
        check("conv_reset", converter_reset, 1'b1);
        @(negedge sys_clk);
        check("conv_reset", converter_reset, 1'b0);
        check("flag_held", overrange_flag, 1'b1);
        repeat (2) @(negedge sys_clk);
        check("conv_reset", converter_reset, 1'b0);
        send(16'h0000, 1'b0);
        wr(OVR_ADDR, 8'h00);
    endtask : t_auto

    task automatic t_modreset;
        mr_count = 0;
        analog_trip = 1'b1;
        repeat (12) @(negedge sys_clk);
        analog_trip = 1'b0;
        repeat (20) @(negedge sys_clk);
        check("mod_resets", mr_count[15:0], 16'h0000);
        analog_trip = 1'b1;
        repeat (16) @(negedge sys_clk);
        check("mod_resets", mr_count[15:0], 16'h0000);
        repeat (6) @(negedge sys_clk);
        check("mod_resets", mr_count[15:0], 16'h0001);
        analog_trip = 1'b0;
    endtask : t_modreset

    initial
    begin
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        t_regs();
        t_formats();
        t_dco_inv();
        t_thresh();
        t_indicate();
        t_auto();
        t_modreset();
        end_of_test();
    end
endmodule : adc_output_format_overrange_bench
`default_nettype wire

// File: capture_model.sv
// Capture register at the far side of the converter output pins.
// Assumes the pins and data_clock_out all change on sys_clk edges.
`timescale 1ns/1ps
`default_nettype none
module capture_model (
    // Pins from the converter
    input  wire logic [15:0] data_out,
    input  wire logic        data_clock_out,
    input  wire logic        overrange_flag,
    // Mirror of the clock invert setting
    input  wire logic        dco_inv,
    // Captured word and flag
    output var  logic [15:0] cap_data,
    output var  logic        cap_flag
);
    wire logic valid_edge;

    // Valid edge is rising unless the clock is inverted
    assign valid_edge = data_clock_out ^ dco_inv;
    // Flag lasts many cycles, so taking it with the word is safe
    always @(posedge valid_edge)
    begin
        cap_data <= data_out;
        cap_flag <= overrange_flag;
    end
endmodule : capture_model
`default_nettype wire

// File: output_coder.sv
// Recodes a twos complement sample into the selected output coding.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module output_coder
    import adc_out_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Select and data
    input  wire out_format_t      fmt,
    input  wire logic [WIDTH-1:0] sample,
    output logic      [WIDTH-1:0] coded
);
    logic [WIDTH-1:0] offset_bin;

    assign offset_bin = {~sample[WIDTH-1], sample[WIDTH-2:0]};

    always_comb
    begin
        case (fmt)
            FMT_TWOS: coded = sample;
            FMT_GRAY: coded = offset_bin ^ (offset_bin >> 1);
            default:  coded = offset_bin;
        endcase
    end
endmodule : output_coder
`default_nettype wire

// File: sync2.sv
// Two flip-flop synchroniser for a single level.
// Assumes the input is slow compared with sys_clk.
`timescale 1ns/1ps
`default_nettype none
module sync2 (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Level
    input  wire logic din,
    output var  logic dout
);
    logic meta_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end
        else
        begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule : sync2
`default_nettype wire
